// ===== verilog/dwc_ctrl_host.sv
// Controller end: AHB-Lite registers, two-entry frame buffer and frame serializer.
`timescale 1ns/1ps
`default_nettype none
module dwc_ctrl_host
    import dwc_pkg::*;
#(
    parameter int FIFO_DEPTH = 2,
    parameter int FIFO_WIDTH = DATA_BITS
)
(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // AHB-Lite slave.
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // Link to the device.
    dwc_link_if.ctrl link
);

    localparam int PW = $clog2(FIFO_DEPTH);
    localparam logic [2:0] HALF_LOAD = 3'(STROBE_HALF_CYCLES - 1);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW = 2'b01,
        ST_HIGH = 2'b11,
        ST_GAP = 2'b10
    } dwc_state_t;

    // ************
    // Registers and bus slave
    // ************

    logic [31:0] ctrl;
    logic [31:0] data_reg [DATA_WORDS];
    logic alert_seen;
    logic wr_pend;
    logic [7:0] pend_addr;
    logic [31:0] rd_mux;
    logic addr_ph;
    logic push;
    logic pop;
    logic [PW:0] count;
    logic [PW:0] next_count;
    dwc_state_t state;
    logic al_s1;
    logic al_s2;
    logic al_s3;

    assign addr_ph = i_hsel & i_htrans[1] & i_hready;
    assign push = wr_pend & o_hreadyout & (pend_addr == REG_GO);
    assign pop = (state == ST_IDLE) && (count != '0);
    assign next_count = count + (PW+1)'(push) - (PW+1)'(pop);

    // Read value chosen in the address phase; unmapped addresses read zero.
    always_comb
    begin
        rd_mux = 32'h0;
        if (i_haddr[7:0] == REG_CTRL)
            rd_mux = ctrl;
        else if (i_haddr[7:0] == REG_STATUS)
        begin
            rd_mux[STAT_BUSY_BIT] = (state != ST_IDLE) || (count != '0);
            rd_mux[STAT_ALERT_BIT] = alert_seen;
            rd_mux[STAT_LEVEL_LSB +: PW+1] = count;
        end
        for (int i = 0; i < DATA_WORDS; i++)
        begin
            if (i_haddr[7:0] == REG_DATA0 + 8'(4 * i))
                rd_mux = data_reg[i];
        end
    end

    // Bus phases, register writes and the stall of a start while the buffer is full.
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ctrl <= CTRL_RESET;
            for (int i = 0; i < DATA_WORDS; i++)
                data_reg[i] <= 32'h0;
            wr_pend <= 1'b0;
            pend_addr <= 8'h00;
            o_hrdata <= 32'h0;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
        else
        begin
            if (wr_pend && o_hreadyout)
            begin
                if (pend_addr == REG_CTRL)
                begin
                    ctrl <= i_hwdata;
                    ctrl[CTRL_DM_BIT] <= i_hwdata[CTRL_DM_BIT] & ~i_hwdata[CTRL_DBI_BIT]; // see RULE11
                end
                for (int i = 0; i < DATA_WORDS; i++)
                begin
                    if (pend_addr == REG_DATA0 + 8'(4 * i))
                        data_reg[i] <= i_hwdata;
                end
            end
            if (addr_ph)
            begin
                wr_pend <= i_hwrite;
                pend_addr <= i_haddr[7:0];
                o_hrdata <= rd_mux;
                if (i_hwrite && i_haddr[7:0] == REG_GO)
                    o_hreadyout <= (next_count < (PW+1)'(FIFO_DEPTH));
            end
            else if (wr_pend && !o_hreadyout)
                o_hreadyout <= (count < (PW+1)'(FIFO_DEPTH));
            else if (o_hreadyout)
                wr_pend <= 1'b0;
        end
    end

    // Alert pin is synchronised; a falling edge sets a sticky bit, write one clears, set wins.
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            al_s1 <= 1'b1;
            al_s2 <= 1'b1;
            al_s3 <= 1'b1;
            alert_seen <= 1'b0;
        end
        else
        begin
            al_s1 <= link.alert_n;
            al_s2 <= al_s1;
            al_s3 <= al_s2;
            if (al_s3 && !al_s2)
                alert_seen <= 1'b1; // see RULE15
            else if (wr_pend && o_hreadyout && pend_addr == REG_STATUS &&
                i_hwdata[STAT_ALERT_BIT])
                alert_seen <= 1'b0;
        end
    end

    // ************
    // Two-entry frame buffer
    // ************

    logic [FIFO_WIDTH-1:0] fifo_mem [FIFO_DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [32*DATA_WORDS-1:0] staged;

    // Data registers packed into one write word.
    always_comb
    begin
        staged = '0;
        for (int i = 0; i < DATA_WORDS; i++)
            staged[32*i +: 32] = data_reg[i];
    end

    // Ring buffer; a start is only accepted when a slot is free, so no word is lost.
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            for (int i = 0; i < FIFO_DEPTH; i++)
                fifo_mem[i] <= '0;
        end
        else
        begin
            if (push)
            begin
                fifo_mem[wr_ptr] <= staged[FIFO_WIDTH-1:0];
                wr_ptr <= (int'(wr_ptr) == FIFO_DEPTH - 1) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
                rd_ptr <= (int'(rd_ptr) == FIFO_DEPTH - 1) ? '0 : rd_ptr + 1'b1;
            count <= next_count;
        end
    end

    // ************
    // Frame builder and serializer
    // ************

    dwc_width_t width;
    logic crc_en;
    logic mask_on;
    logic [FRAME_BITS-1:0] built;
    logic [FRAME_BITS-1:0] tx_frame;
    logic [7:0] crc_lo;
    logic [7:0] crc_hi;
    logic [3:0] beat;
    logic [2:0] half;

    assign width = dwc_width_t'(ctrl[CTRL_WIDTH_LSB +: 2]);
    assign crc_en = ctrl[CTRL_CRC_BIT];
    assign mask_on = ctrl[CTRL_DBI_BIT] | ctrl[CTRL_DM_BIT];

    // Lays out the head word, fills unused places with ones and appends the checksums.
    always_comb
    begin
        built = '1;
        for (int l = 0; l < LANES; l++)
        begin
            for (int t = 0; t < BEATS_PLAIN; t++)
                built[l*BEATS_CRC + t] = fifo_mem[rd_ptr][l*BEATS_PLAIN + t];
            if ((l % TREE_LANES == MASK_OFS && !mask_on) ||
                (width == DWC_X4 && l >= X4_LANES) || (width == DWC_X8 && l >= UPPER_BASE))
                built[l*BEATS_CRC +: BEATS_PLAIN] = '1; // see RULE7 see RULE8
        end
        crc_lo = dwc_crc8(dwc_tree_word(built, 0, width, mask_on)); // see RULE1 see RULE2
        crc_hi = dwc_crc8(dwc_tree_word(built, UPPER_BASE, width, mask_on));
        for (int j = 0; j < 8; j++)
        begin
            if (width == DWC_X4)
            begin
                if (j < X4_LANES)
                begin
                    built[j*BEATS_CRC + CRC_BEAT_A] = crc_lo[j]; // see RULE16
                    built[j*BEATS_CRC + CRC_BEAT_B] = crc_lo[j + X4_LANES];
                end
            end
            else
            begin
                built[j*BEATS_CRC + CRC_BEAT_A] = crc_lo[j]; // see RULE6
                if (width == DWC_X16)
                    built[(UPPER_BASE + j)*BEATS_CRC + CRC_BEAT_A] = crc_hi[j];
            end
        end
    end

    // Strobe from a divider: data set while low, the device samples on the rising edge.
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state <= ST_IDLE;
            tx_frame <= '1;
            beat <= '0;
            half <= '0;
            link.dq <= '1;
            link.dqs <= 1'b0;
            link.frame_act <= 1'b0;
        end
        else
        begin
            if (half != 3'h0)
                half <= half - 3'h1;
            case (state)
                ST_IDLE:
                begin
                    if (pop)
                    begin
                        tx_frame <= built;
                        beat <= '0;
                        half <= HALF_LOAD;
                        link.frame_act <= 1'b1;
                        for (int l = 0; l < LANES; l++)
                            link.dq[l] <= built[l*BEATS_CRC];
                        state <= ST_LOW;
                    end
                end
                ST_LOW:
                begin
                    if (half == 3'h0)
                    begin
                        link.dqs <= 1'b1;
                        half <= HALF_LOAD;
                        state <= ST_HIGH;
                    end
                end
                ST_HIGH:
                begin
                    if (half == 3'h0)
                    begin
                        link.dqs <= 1'b0;
                        half <= HALF_LOAD;
                        if (int'(beat) == (crc_en ? BEATS_CRC : BEATS_PLAIN) - 1) // see RULE18
                        begin
                            link.frame_act <= 1'b0;
                            state <= ST_GAP;
                        end
                        else
                        begin
                            beat <= beat + 4'h1;
                            for (int l = 0; l < LANES; l++)
                                link.dq[l] <= tx_frame[l*BEATS_CRC + int'(beat) + 1];
                            state <= ST_LOW;
                        end
                    end
                end
                ST_GAP:
                begin
                    if (half == 3'h0)
                        state <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

endmodule : dwc_ctrl_host
`default_nettype wire

// ===== verilog/dwc_pkg.sv
// Shared constants, types and checksum functions of the write checksum link.
package dwc_pkg;

    // ************
    // Timing
    // ************
    localparam int MCLK_PERIOD_NS = 25;
    localparam int LINK_PERIOD_NS = 200;
    localparam int STROBE_HALF_CYCLES = LINK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
    localparam int ALERT_PW_MIN_TCK = 6;
    localparam int ALERT_PW_MAX_TCK = 10;
    localparam int ALERT_PW_CYCLES = (ALERT_PW_MIN_TCK + ALERT_PW_MAX_TCK) / 2;

    // ************
    // Frame layout
    // ************
    localparam int LANES = 18;
    localparam int BEATS_CRC = 10;
    localparam int BEATS_PLAIN = 8;
    localparam int FRAME_BITS = LANES * BEATS_CRC;
    localparam int DATA_BITS = LANES * BEATS_PLAIN;
    localparam int TREE_LANES = 9;
    localparam int TREE_BITS = 72;
    localparam int UPPER_BASE = 9;
    localparam int MASK_OFS = 8;
    localparam int X4_LANES = 4;
    localparam int CRC_BEAT_A = 8;
    localparam int CRC_BEAT_B = 9;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;

    typedef enum logic [1:0] {
        DWC_X4 = 2'h0,
        DWC_X8 = 2'h1,
        DWC_X16 = 2'h2
    } dwc_width_t;

    // ************
    // Controller register map
    // ************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DATA0 = 8'h04;
    localparam int DATA_WORDS = 5;
    localparam logic [7:0] REG_GO = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1c;
    localparam int CTRL_CRC_BIT = 0;
    localparam int CTRL_DBI_BIT = 1;
    localparam int CTRL_DM_BIT = 2;
    localparam int CTRL_WIDTH_LSB = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ALERT_BIT = 1;
    localparam int STAT_LEVEL_LSB = 2;

    // Serial checksum, first bit d[71], zero start; synthesis flattens it to XOR trees.
    function automatic logic [7:0] dwc_crc8(input logic [TREE_BITS-1:0] d);
        logic [7:0] c;
        logic fb;
        c = CRC_INIT;
        for (int i = TREE_BITS - 1; i >= 0; i--)
        begin
            fb = c[7] ^ d[i];
            c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction : dwc_crc8

    // Gathers one tree's 72 inputs from a frame, forcing unused inputs to one.
    function automatic logic [TREE_BITS-1:0] dwc_tree_word(input logic [FRAME_BITS-1:0] f,
        input int base, input dwc_width_t width, input logic mask_on);
        logic [TREE_BITS-1:0] w;
        logic b;
        w = '0;
        for (int n = 0; n < TREE_LANES; n++)
        begin
            for (int k = 0; k < BEATS_PLAIN; k++)
            begin
                b = f[(base + n) * BEATS_CRC + k];
                if (n == MASK_OFS && !mask_on)
                    b = 1'b1;
                if (width == DWC_X4 && n >= X4_LANES)
                    b = 1'b1;
                w[n * BEATS_PLAIN + k] = b;
            end
        end
        return w;
    endfunction : dwc_tree_word

    // Picks the checksum bits out of the final transfers of a frame.
    function automatic logic [7:0] dwc_rx_crc(input logic [FRAME_BITS-1:0] f, input int base,
        input dwc_width_t width);
        logic [7:0] c;
        c = '0;
        for (int j = 0; j < 8; j++)
        begin
            if (width == DWC_X4)
                c[j] = (j < X4_LANES) ? f[j * BEATS_CRC + CRC_BEAT_A] :
                    f[(j - X4_LANES) * BEATS_CRC + CRC_BEAT_B];
            else
                c[j] = f[(base + j) * BEATS_CRC + CRC_BEAT_A];
        end
        return c;
    endfunction : dwc_rx_crc

endpackage : dwc_pkg

// ===== verilog/dwc_link_if.sv
// Link between the write controller and the checking device.
`timescale 1ns/1ps
`default_nettype none
interface dwc_link_if
    import dwc_pkg::*;
    ;
    logic [LANES-1:0] dq;
    logic dqs;
    logic frame_act;
    logic alert_drv;
    logic alert_oe;
    logic alert_n;

    // Open-drain alert wire with a pull-up when nobody drives it.
    assign alert_n = alert_oe ? alert_drv : 1'b1;

    modport dev (input dq, input dqs, input frame_act, input alert_n,
        output alert_drv, output alert_oe);
    modport ctrl (output dq, output dqs, output frame_act, input alert_n);
endinterface : dwc_link_if
`default_nettype wire

// ===== verilog/dwc_dev_checker.sv
// Device end: receives write frames, recomputes the checksum and pulses the alert pin.
//
// Notes on behaviour
// RULE1: Checksum polynomial x8+x2+x+1 over 72 bits.
// RULE2: Bit 71 goes first, remainder starts zero.
// RULE3: All eight bits in one combinational step.
// RULE4: Eight parallel XOR trees, shallow and flat.
// RULE5: Catches single, double, odd and column errors.
// RULE6: Controller appends checksum to every write burst; this one only when the checksum enable bit is set.
// RULE7: Byte part: ones in transfer nine, mask lane.
// RULE8: Word part: ones in transfer nine, both mask lanes.
// RULE9: Mismatch between received and computed raises alert.
// RULE10: Byte part: mask lane inputs, else forced ones.
// RULE11: Controller never enables inversion and masking together.
// RULE12: Word part: two trees, upper bytes forced ones; here lanes 9 to 17 feed the second tree as data.
// RULE13: Nibble part: 32 data inputs, rest ones.
// RULE14: Data delivered without waiting for the check.
// RULE15: Controller retries failed writes and keeps coherence; this controller does not retry, it only sets a sticky alert status bit.
// RULE16: Nibble lanes carry checksum bits n, n+4.
// RULE17: Alert low pulse of six to ten clocks.
// RULE18: Checked frames are always ten transfers long.
// RULE19: Check only when enabled, else eight transfers.
`timescale 1ns/1ps
`default_nettype none
module dwc_dev_checker
    import dwc_pkg::*;
(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // Link to the controller.
    dwc_link_if.dev link,
    // Mode settings held by the device's mode logic.
    input wire logic i_crc_en,
    input wire logic i_dbi_en,
    input wire logic i_dm_en,
    input wire dwc_width_t i_width,
    // Received write data.
    output logic [DATA_BITS-1:0] o_word,
    output logic o_valid,
    output logic o_crc_err
);

    localparam logic [3:0] LAST_CRC = 4'(BEATS_CRC - 1);
    localparam logic [3:0] LAST_PLAIN = 4'(BEATS_PLAIN - 1);
    localparam logic [3:0] PW_LOAD = 4'(ALERT_PW_CYCLES - 1);

    // ************
    // Pin synchronisers
    // ************

    logic [LANES-1:0] dq_s1;
    logic [LANES-1:0] dq_s2;
    logic dqs_s1;
    logic dqs_s2;
    logic dqs_s3;
    logic frm_s1;
    logic frm_s2;

    // Every link pin passes two flip-flops; the strobe gets a third for edge finding.
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            dq_s1 <= '0;
            dq_s2 <= '0;
            dqs_s1 <= 1'b0;
            dqs_s2 <= 1'b0;
            dqs_s3 <= 1'b0;
            frm_s1 <= 1'b0;
            frm_s2 <= 1'b0;
        end
        else
        begin
            dq_s1 <= link.dq;
            dq_s2 <= dq_s1;
            dqs_s1 <= link.dqs;
            dqs_s2 <= dqs_s1;
            dqs_s3 <= dqs_s2;
            frm_s1 <= link.frame_act;
            frm_s2 <= frm_s1;
        end
    end

    logic strobe_rise;

    // A rising strobe marks one transfer on all lanes.
    assign strobe_rise = dqs_s2 & ~dqs_s3;

    // ************
    // Frame capture
    // ************

    logic [3:0] beat;
    logic [3:0] last_beat;
    logic [FRAME_BITS-1:0] frame;
    logic done;

    // The frame length follows the checksum enable.
    assign last_beat = i_crc_en ? LAST_CRC : LAST_PLAIN; // see RULE18 see RULE19

    // Counts transfers inside a frame and restarts whenever the frame signal drops.
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            beat <= '0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (!frm_s2)
                beat <= '0;
            else if (strobe_rise)
            begin
                if (beat == last_beat)
                begin
                    beat <= '0;
                    done <= 1'b1;
                end
                else
                    beat <= beat + 4'h1;
            end
        end
    end

    // Each lane stores its bit of the current transfer; bit index is lane*10+transfer.
    for (genvar l = 0; l < LANES; l++)
    begin : g_lane
        logic [BEATS_CRC-1:0] bits;
        always_ff @(posedge i_mclk or negedge i_reset_n)
        begin
            if (!i_reset_n)
                bits <= '1;
            else if (frm_s2 && strobe_rise)
                bits[beat] <= dq_s2[l]; // see RULE16
        end
        assign frame[l*BEATS_CRC +: BEATS_CRC] = bits;
    end

    // ************
    // Checksum comparison
    // ************

    logic mask_on;
    logic [7:0] calc_lo;
    logic [7:0] calc_hi;
    logic [7:0] rx_lo;
    logic [7:0] rx_hi;
    logic mismatch;

    // The mask lane feeds the tree only when inversion or masking is on.
    assign mask_on = i_dbi_en | i_dm_en; // see RULE10 see RULE12

    // Lower tree covers lanes 0 to 8; nibble parts force inputs above 31 to one.
    assign calc_lo = dwc_crc8(dwc_tree_word(frame, 0, i_width, mask_on)); // see RULE13

    // Upper tree is an identical copy over lanes 9 to 17.
    assign calc_hi = dwc_crc8(dwc_tree_word(frame, UPPER_BASE, i_width, mask_on)); // see RULE12

    // Received checksum bits from the final transfers.
    assign rx_lo = dwc_rx_crc(frame, 0, i_width); // see RULE16
    assign rx_hi = dwc_rx_crc(frame, UPPER_BASE, i_width);

    // Any differing bit in a used tree counts as an error.
    // One flat XOR network per bit gives full single, double and odd coverage.
    assign mismatch = (calc_lo != rx_lo) |
        ((i_width == DWC_X16) && (calc_hi != rx_hi)); // see RULE1 see RULE2 see RULE3 see RULE4 see RULE5 see RULE9

    // ************
    // Delivery
    // ************

    // Data leaves at the same edge as the verdict, so a full write never waits on it.
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_word <= '0;
            o_valid <= 1'b0;
            o_crc_err <= 1'b0;
        end
        else
        begin
            o_valid <= done; // see RULE14
            o_crc_err <= done & i_crc_en & mismatch; // see RULE9 see RULE19
            if (done)
            begin
                for (int l = 0; l < LANES; l++)
                begin
                    for (int k = 0; k < BEATS_PLAIN; k++)
                        o_word[l*BEATS_PLAIN + k] <= frame[l*BEATS_CRC + k];
                end
            end
        end
    end

    // ************
    // Alert pulse
    // ************

    logic [3:0] pw_cnt;

    // Each error starts a fresh low pulse; a second error restarts the width.
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pw_cnt <= '0;
            link.alert_oe <= 1'b0;
            link.alert_drv <= 1'b0;
        end
        else
        begin
            link.alert_drv <= 1'b0;
            if (done && i_crc_en && mismatch)
            begin
                pw_cnt <= PW_LOAD; // see RULE17
                link.alert_oe <= 1'b1; // see RULE9
            end
            else if (pw_cnt != 4'h0)
                pw_cnt <= pw_cnt - 4'h1;
            else
                link.alert_oe <= 1'b0; // see RULE17
        end
    end

endmodule : dwc_dev_checker
`default_nettype wire

// ===== tb/dwc_link_asserts.sv
// Checker of the write checksum link wires.
`timescale 1ns/1ps
`default_nettype none
module dwc_link_asserts
    import dwc_pkg::*;
(
    // Clock, reset and link wires.
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [LANES-1:0] dq,
    input wire logic dqs,
    input wire logic frame_act,
    input wire logic alert_oe,
    input wire logic alert_n
);
    logic [3:0] beat;
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);
    // Counts strobe falls inside a frame.
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            beat <= 4'h0;
        else if (!frame_act)
            beat <= 4'h0;
        else if ($fell(dqs))
            beat <= beat + 4'h1;
    end
    a_frame_start: assert property ($rose(frame_act) |-> !dqs [*4] ##1 dqs)
        else $error("strobe late at frame start");
    a_strobe_half: assert property ($rose(dqs) |-> dqs [*4] ##1 !dqs)
        else $error("strobe high time wrong");
    a_frame_len: assert property ($fell(frame_act) |-> beat == 4'h7 || beat == 4'h9)
        else $error("frame length not 8 or 10");
    a_beat_hold: assert property (frame_act && $past(frame_act) && $changed(dq) |-> $fell(dqs))
        else $error("data moved inside a transfer");
    a_last_ones: assert property (frame_act && beat == 4'h9 |-> &dq[17:4])
        else $error("final transfer lanes not ones");
    a_mask_ones: assert property (frame_act && beat >= 4'h8 |-> dq[8] && dq[17])
        else $error("mask lane checksum transfers not ones");
    a_alert_width: assert property ($rose(alert_oe) |-> alert_oe [*8] ##1 !alert_oe)
        else $error("alert pulse width wrong");
    a_alert_low: assert property (alert_oe |-> !alert_n)
        else $error("alert wire not low");
    a_alert_cause: assert property ($rose(alert_oe) |-> $fell(frame_act) && beat == 4'h9)
        else $error("alert after unchecked frame");
    c_alert: cover property ($rose(alert_oe));
    c_short: cover property ($fell(frame_act) && beat == 4'h7);
    c_long: cover property ($fell(frame_act) && beat == 4'h9);
endmodule : dwc_link_asserts
`default_nettype wire

// ===== tb/ddr4_write_crc_checker_bench.sv
// Self-checking bench joining the controller and the device ends.
`timescale 1ns/1ps
`default_nettype none
module ddr4_write_crc_checker_bench
    import dwc_pkg::*;
;
    logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, crc = 0, dbi = 0, dm = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0] htrans = 0;
    logic hrdy, ov, oe, hresp;
    logic [143:0] ow, m;
    logic [159:0] d;
    logic [6:0] c;
    dwc_width_t wd = DWC_X4;
    logic [143:0] qw[$], qm[$];
    logic qe[$];
    int err_count = 0, num_checks = 0;
    logic [6:0] cfg[7] = '{7'h63, 7'h65, 7'h11, 7'h01, 7'h23, 7'h12, 7'h53};
    dwc_link_if lnk();
    dwc_ctrl_host i_dwc_ctrl_host (.i_mclk(clk), .i_reset_n(rst_n), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy),
        .o_hresp(hresp), .link(lnk));
    dwc_dev_checker i_dwc_dev_checker (.i_mclk(clk), .i_reset_n(rst_n), .link(lnk),
        .i_crc_en(crc), .i_dbi_en(dbi), .i_dm_en(dm), .i_width(wd), .o_word(ow),
        .o_valid(ov), .o_crc_err(oe));
    dwc_link_asserts i_dwc_link_asserts (.i_mclk(clk), .i_reset_n(rst_n), .dq(lnk.dq),
        .dqs(lnk.dqs), .frame_act(lnk.frame_act), .alert_oe(lnk.alert_oe), .alert_n(lnk.alert_n));
    // Serial reference checksum, bit 71 first from a zero remainder.
    function automatic logic [7:0] ck(input logic [71:0] x);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 71; i >= 0; i--)
            s = {s[6:0], 1'b0} ^ ((s[7] ^ x[i]) ? 8'h07 : 8'h00);
        return s;
    endfunction : ck
    // Tree inputs with unused groups forced to one.
    function automatic logic [71:0] tr(input logic [71:0] x, input logic k, input logic n);
        if (!k) x[71:64] = 8'hff;
        if (n) x[71:32] = '1;
        return x;
    endfunction : tr
    task automatic chk(input logic [144:0] g, input logic [144:0] e);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // One single AHB-Lite transfer.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h0, a, 2'h2, w};
        do @(posedge clk); while (hrdy !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, v};
        do @(posedge clk); while (hrdy !== 1'b1);
        r = hrdata;
    endtask : bus
    task automatic summarize();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize
    // Clock of 25 ns.
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    // Every received word against the reference queue.
    always @(negedge clk)
    begin
        if (ov === 1'b1)
            chk({oe, ow & qm.pop_front()}, {qe.pop_front(), qw.pop_front()});
    end
    // Cuts a hang short.
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        summarize();
    end
    // Modes in turn, three frames each to fill the buffer.
    initial
    begin
        void'($urandom(24675));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        bus(1, 8'h00, 32'h7);
        bus(0, 8'h00, 32'h0);
        chk(r, 32'h3);
        bus(0, 8'h40, 32'h0);
        chk(r, 32'h0);
        foreach (cfg[i])
        begin
            c = cfg[i];
            bus(1, 8'h00, {26'h0, c[5:0]});
            {crc, dbi, dm} <= {c[0], c[6] & c[1], c[6] & c[2]};
            wd <= dwc_width_t'(c[5:4]);
            m = (c[5:4] == 2'h0) ? 144'hffffffff : 144'hffffffffffffffff;
            m[135:72] = (c[5:4] == 2'h2) ? '1 : '0;
            repeat (3)
            begin
                for (int k = 0; k < 5; k++)
                begin
                    d[k*32+:32] = $urandom;
                    bus(1, 8'h04 + 8'(4 * k), d[k*32+:32]);
                end
                qw.push_back(d[143:0] & m);
                qm.push_back(m);
                qe.push_back(c[0] && (ck(tr(d[71:0], c[1] | c[2], c[5:4] == 2'h0))
                    != ck(tr(d[71:0], c[6], c[5:4] == 2'h0)) || c[5:4] == 2'h2
                    && ck(tr(d[143:72], c[1] | c[2], 0)) != ck(tr(d[143:72], c[6], 0))));
                bus(1, 8'h18, 32'h0);
            end
            do bus(0, 8'h1c, 32'h0); while (r[0]);
            repeat (30) @(posedge clk);
            bus(0, 8'h1c, 32'h0);
            chk(r[1], i == 4);
            bus(1, 8'h1c, 32'h2);
        end
        chk(qw.size(), 0);
        chk(hresp, 0);
        summarize();
    end
endmodule : ddr4_write_crc_checker_bench
`default_nettype wire
